//--- csb_defs.svh
// constants for the chip-select burst read sequencer
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH

// operand size codes driven on the size pins
`define CSB_OSZ_LONG 2'h0
`define CSB_OSZ_BYTE 2'h1
`define CSB_OSZ_WORD 2'h2
`define CSB_OSZ_LINE 2'h3

// port width codes
`define CSB_PORT_32 2'h0
`define CSB_PORT_8 2'h1
`define CSB_PORT_16 2'h2

// pin levels and reset values
`define CSB_STROBES_OFF 4'hf
`define CSB_ADDR_RST 28'h0000000
`define CSB_DATA_RST 32'h00000000

// data lane positions
`define CSB_LANE8_LSB 24
`define CSB_LANE16_LSB 16

`endif

//--- csb_pkg.sv
// types shared by the chip-select burst read sequencer
package csb_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_BEAT,
		ST_HOLD,
		ST_ADV
	} csb_state_t;

endpackage

//--- csb_sync.sv
// two-flop synchroniser for bus pin inputs
`timescale 1ns/10ps
module csb_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

//--- csb_bus_monitor.sv
// bus monitor: flags a beat that waits too long for its acknowledge
`timescale 1ns/10ps
module csb_bus_monitor (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic i_enable,
	input wire logic [7:0] i_limit,
	output logic o_timeout
);

	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic tmo_r;
	logic tmo_nxt;

	// counts clocks spent waiting in one beat; a fresh beat restarts it
	always_comb begin
		cnt_nxt = 8'h00;
		tmo_nxt = 1'b0;
		if (i_run && i_enable && !tmo_r) begin
			if (cnt_r == i_limit) begin
				tmo_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cnt_r <= 8'h00;
			tmo_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tmo_r <= tmo_nxt;
		end
	end

	assign o_timeout = tmo_r;

endmodule

//--- csb_read_seq.sv
// chip-select burst read sequencer: drives the external bus for read cycles
`timescale 1ns/10ps
`include "csb_defs.svh"

// What this block does
// - first clock asserts begin strobe; second negates it and drives supervisor/user class
// - first clock drives address, access kind, and class high for code fetch
// - reads hold direction and write strobes high; size code per operand, or port width for unbursted wide operands
// - on 16-bit port, acknowledged beat captures upper data half
// - on 8-bit port, each beat carries one byte on top lines
// - negated acknowledge inserts wait states, sampled every clock until asserted
// - enabled bus monitor expiry ends the cycle with a bus error
// - longword on 16-bit port advances A[1:0] after first acknowledged beat
// - word on 8-bit port advances A[0] after first acknowledged byte
// - final acknowledged beat ends the burst and negates chip select
// - setup option keeps chip select negated first clock and each advance clock
// - setup option asserts chip select in second clock, negates after non-final beats
// - hold option keeps address and attributes one extra clock after each beat
// - burst size code shows operand size, not port width
// - burst only when enabled and operand wider than port; else single transfers
module csb_read_seq
	import csb_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic [27:0] i_req_addr,
	input wire logic [1:0] i_req_kind,
	input wire logic i_req_code,
	input wire logic i_req_super,
	input wire logic [1:0] i_req_size,
	input wire logic [1:0] i_port_size,
	input wire logic i_burst_en,
	input wire logic i_setup_delay_enable,
	input wire logic i_addr_hold_en,
	input wire logic i_bmon_en,
	input wire logic [7:0] i_bmon_limit,
	input wire logic i_beat_acknowledge_n,
	input wire logic [31:0] i_data,
	output logic [27:0] o_addr,
	output logic o_cycle_begin_strobe_n,
	output logic o_access_class_attr,
	output logic [1:0] o_access_kind_code,
	output logic [1:0] o_operand_size_code,
	output logic o_rw,
	output logic [3:0] o_write_strobe_n,
	output logic o_cs_n,
	output logic o_busy,
	output logic [31:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_done,
	output logic o_bus_error
);

	// ****************************************
	// decoding helpers
	// ****************************************
	function automatic logic [4:0] op_bytes(input logic [1:0] osz);
		unique case (osz)
			`CSB_OSZ_BYTE: op_bytes = 5'h01;
			`CSB_OSZ_WORD: op_bytes = 5'h02;
			`CSB_OSZ_LONG: op_bytes = 5'h04;
			`CSB_OSZ_LINE: op_bytes = 5'h10;
		endcase
	endfunction

	function automatic logic [4:0] port_bytes(input logic [1:0] port);
		unique case (port)
			`CSB_PORT_8: port_bytes = 5'h01;
			`CSB_PORT_16: port_bytes = 5'h02;
			default: port_bytes = 5'h04;
		endcase
	endfunction

	function automatic logic [1:0] port_opsz(input logic [1:0] port);
		unique case (port)
			`CSB_PORT_8: port_opsz = `CSB_OSZ_BYTE;
			`CSB_PORT_16: port_opsz = `CSB_OSZ_WORD;
			default: port_opsz = `CSB_OSZ_LONG;
		endcase
	endfunction

	// step the low address bits by one port width, wrapping inside the operand
	function automatic logic [27:0] addr_step(input logic [27:0] a, input logic [1:0] osz,
			input logic [1:0] port);
		logic [3:0] m;
		logic [3:0] s;
		m = 4'(op_bytes(osz) - 5'h01);
		s = a[3:0] + 4'(port_bytes(port));
		addr_step = {a[27:4], (a[3:0] & ~m) | (s & m)};
	endfunction

	// ****************************************
	// pin synchronisers and bus monitor
	// ****************************************
	logic ack_n_s;
	logic [31:0] data_s;
	logic tmo;
	csb_state_t state_r;
	csb_state_t state_nxt;

	csb_sync #(.WIDTH(33), .RST_VAL({1'b1, 32'h00000000})) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_beat_acknowledge_n, i_data}),
		.o_sync({ack_n_s, data_s})
	);

	csb_bus_monitor u_bmon (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		// only clocks still waiting count, so every acknowledged beat restarts the monitor
		.i_run(state_r == ST_BEAT && ack_n_s),
		.i_enable(i_bmon_en),
		.i_limit(i_bmon_limit),
		.o_timeout(tmo)
	);

	// ****************************************
	// sequencer state
	// ****************************************
	logic [4:0] beats_r, beats_nxt;
	logic [1:0] opsz_r, opsz_nxt;
	logic [1:0] port_r, port_nxt;
	logic burst_r, burst_nxt;
	logic setup_r, setup_nxt;
	logic hold_r, hold_nxt;
	logic code_r, code_nxt;
	logic super_r, super_nxt;
	logic last_r, last_nxt;
	logic [2:0] acc_r, acc_nxt;
	logic [27:0] addr_nxt;
	logic [1:0] kind_nxt;
	logic [31:0] data_nxt;
	logic begin_n_nxt, attr_nxt, cs_n_nxt, valid_nxt, done_nxt, err_nxt;
	logic [1:0] osiz_nxt;
	logic beat_ok;
	logic [4:0] pb;

	assign beat_ok = (state_r == ST_BEAT) && !ack_n_s && !tmo;
	assign pb = port_bytes(port_r);

	always_comb begin
		state_nxt = state_r;
		beats_nxt = beats_r;
		opsz_nxt = opsz_r;
		port_nxt = port_r;
		burst_nxt = burst_r;
		setup_nxt = setup_r;
		hold_nxt = hold_r;
		code_nxt = code_r;
		super_nxt = super_r;
		last_nxt = last_r;
		acc_nxt = acc_r;
		addr_nxt = o_addr;
		kind_nxt = o_access_kind_code;
		data_nxt = o_rd_data;
		valid_nxt = 1'b0;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (i_req) begin
					state_nxt = ST_START;
					addr_nxt = i_req_addr;
					kind_nxt = i_req_kind;
					opsz_nxt = i_req_size;
					port_nxt = i_port_size;
					setup_nxt = i_setup_delay_enable;
					hold_nxt = i_addr_hold_en;
					code_nxt = i_req_code;
					super_nxt = i_req_super;
					last_nxt = 1'b0;
					acc_nxt = 3'h0;
					// wide operands become several beats, bursted only when allowed
					burst_nxt = i_burst_en;
					if (op_bytes(i_req_size) > port_bytes(i_port_size)) begin
						beats_nxt = op_bytes(i_req_size) / port_bytes(i_port_size);
					end else begin
						beats_nxt = 5'h01;
					end
				end
			end
			ST_START: begin
				state_nxt = ST_BEAT;
			end
			ST_BEAT: begin
				if (tmo) begin
					// outstanding beats are dropped; the cycle is released at once
					state_nxt = ST_IDLE;
					err_nxt = 1'b1;
				end else if (!ack_n_s) begin
					unique case (port_r)
						`CSB_PORT_8: data_nxt = {o_rd_data[23:0], data_s[31:24]};
						`CSB_PORT_16: data_nxt = {o_rd_data[15:0], data_s[31:16]};
						default: data_nxt = data_s;
					endcase
					acc_nxt = 3'(acc_r + pb[2:0]);
					beats_nxt = beats_r - 5'h01;
					if (3'(acc_r + pb[2:0]) == 3'h4 || beats_r == 5'h01) begin
						valid_nxt = 1'b1;
						acc_nxt = 3'h0;
					end
					if (beats_r == 5'h01) begin
						done_nxt = 1'b1;
						last_nxt = 1'b1;
						state_nxt = hold_r ? ST_HOLD : ST_IDLE;
					end else if (hold_r) begin
						state_nxt = ST_HOLD;
					end else begin
						addr_nxt = addr_step(o_addr, opsz_r, port_r);
						if (!burst_r) begin
							state_nxt = ST_START;
						end else if (setup_r) begin
							state_nxt = ST_ADV;
						end else begin
							state_nxt = ST_BEAT;
						end
					end
				end
				// otherwise wait states: the acknowledge is sampled again next clock
			end
			ST_HOLD: begin
				if (last_r) begin
					state_nxt = ST_IDLE;
				end else begin
					addr_nxt = addr_step(o_addr, opsz_r, port_r);
					if (!burst_r) begin
						state_nxt = ST_START;
					end else begin
						state_nxt = setup_r ? ST_ADV : ST_BEAT;
					end
				end
			end
			ST_ADV: begin
				state_nxt = ST_BEAT;
			end
		endcase
	end

	// ****************************************
	// pin values follow the next state so every pin leaves a flip-flop
	// ****************************************
	always_comb begin
		begin_n_nxt = (state_nxt != ST_START);
		attr_nxt = (state_nxt == ST_START) ? code_nxt : super_nxt;
		// setup keeps the select off in the strobe clock and advance clocks
		cs_n_nxt = !((state_nxt == ST_BEAT) || (state_nxt == ST_START && !setup_nxt));
		if (state_nxt == ST_IDLE) begin
			osiz_nxt = o_operand_size_code;
		end else if (op_bytes(opsz_nxt) > port_bytes(port_nxt) && !burst_nxt) begin
			osiz_nxt = port_opsz(port_nxt);
		end else begin
			osiz_nxt = opsz_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
			beats_r <= 5'h00;
			opsz_r <= `CSB_OSZ_LONG;
			port_r <= `CSB_PORT_32;
			burst_r <= 1'b0;
			setup_r <= 1'b0;
			hold_r <= 1'b0;
			code_r <= 1'b0;
			super_r <= 1'b0;
			last_r <= 1'b0;
			acc_r <= 3'h0;
			o_addr <= `CSB_ADDR_RST;
			o_access_kind_code <= 2'h0;
			o_operand_size_code <= `CSB_OSZ_LONG;
			o_cycle_begin_strobe_n <= 1'b1;
			o_access_class_attr <= 1'b0;
			o_cs_n <= 1'b1;
			o_rw <= 1'b1;
			o_write_strobe_n <= `CSB_STROBES_OFF;
			o_busy <= 1'b0;
			o_rd_data <= `CSB_DATA_RST;
			o_rd_valid <= 1'b0;
			o_done <= 1'b0;
			o_bus_error <= 1'b0;
		end else begin
			state_r <= state_nxt;
			beats_r <= beats_nxt;
			opsz_r <= opsz_nxt;
			port_r <= port_nxt;
			burst_r <= burst_nxt;
			setup_r <= setup_nxt;
			hold_r <= hold_nxt;
			code_r <= code_nxt;
			super_r <= super_nxt;
			last_r <= last_nxt;
			acc_r <= acc_nxt;
			o_addr <= addr_nxt;
			o_access_kind_code <= kind_nxt;
			o_operand_size_code <= osiz_nxt;
			o_cycle_begin_strobe_n <= begin_n_nxt;
			o_access_class_attr <= attr_nxt;
			o_cs_n <= cs_n_nxt;
			// read-only sequencer: no write strobe ever asserts
			o_rw <= 1'b1;
			o_write_strobe_n <= `CSB_STROBES_OFF;
			o_busy <= (state_nxt != ST_IDLE);
			o_rd_data <= data_nxt;
			o_rd_valid <= valid_nxt;
			o_done <= done_nxt;
			o_bus_error <= err_nxt;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_start_clock;
		!o_cycle_begin_strobe_n && o_busy;
	endsequence

	sequence s_second_clock;
		o_cycle_begin_strobe_n && (o_access_class_attr == super_r);
	endsequence

	a_strobe_then_class: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_start_clock |=> s_second_clock) else $error("class or strobe wrong in second clock");

	a_first_class: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_r == ST_START |-> o_access_class_attr == code_r) else $error("class wrong in first clock");

	a_read_pins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_busy |-> o_rw && o_write_strobe_n == 4'hf) else $error("read pins not high");

	a_capture_half: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		beat_ok && port_r == `CSB_PORT_16 |=> o_rd_data[15:0] == $past(data_s[31:16]))
		else $error("upper half not captured");

	a_capture_byte: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		beat_ok && port_r == `CSB_PORT_8 |=> o_rd_data[7:0] == $past(data_s[31:24]))
		else $error("top byte not captured");

	a_wait_state: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_r == ST_BEAT && ack_n_s && !tmo |=> state_r == ST_BEAT && !o_cs_n)
		else $error("beat left without acknowledge");

	a_timeout_end: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_r == ST_BEAT && tmo |=> o_bus_error && o_cs_n && state_r == ST_IDLE)
		else $error("timeout did not end the cycle");

	a_half_advance: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		beat_ok && port_r == `CSB_PORT_16 && opsz_r == `CSB_OSZ_LONG && beats_r == 5'h02 && !hold_r
		|=> o_addr[1:0] == 2'($past(o_addr[1:0]) + 2'h2)) else $error("halfword address not advanced");

	a_byte_advance: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		beat_ok && port_r == `CSB_PORT_8 && opsz_r == `CSB_OSZ_WORD && beats_r == 5'h02 && hold_r
		|=> o_addr == $past(o_addr) ##1 o_addr[0] != $past(o_addr[0])) else $error("byte address");

	a_final_end: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		beat_ok && beats_r == 5'h01 |=> o_done && o_cs_n) else $error("burst did not end");

	a_setup_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_r == ST_START && setup_r |-> o_cs_n ##1 !o_cs_n) else $error("setup select timing");

	a_hold_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_r == ST_HOLD |-> $stable(o_addr) && $stable(o_access_kind_code))
		else $error("address changed in hold clock");

	a_burst_size: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_r == ST_START && burst_r |-> o_operand_size_code == opsz_r)
		else $error("burst size code not operand size");

endmodule

//--- csb_tail_unused_marker.sv
// reserved file: the sequencer keeps no logic here

//--- csb_mem_model.sv
// behavioural memory that answers chip-select read beats
`timescale 1ns/10ps
module csb_mem_model (
	input wire logic i_sys_clk,
	input wire logic [27:0] i_addr,
	input wire logic i_cs_n,
	input wire logic i_cycle_begin_strobe_n,
	input wire logic i_mute,
	input wire logic [3:0] i_wait,
	output logic o_beat_acknowledge_n,
	output logic [31:0] o_data
);
	logic done_r = 1'b0;
	logic [27:0] last_r = 28'h0000000;
	int cnt = 0;
	function automatic logic [7:0] mb(input logic [27:0] a);
		return a[7:0] ^ 8'h3c;
	endfunction
	initial begin
		o_beat_acknowledge_n = 1'b1;
		o_data = 32'h00000000;
	end
	always @(posedge i_sys_clk) begin
		o_beat_acknowledge_n <= 1'b1;
		// released lines toggle so stale data can never pass for a fresh beat
		o_data <= ~o_data;
		// a new transfer or a new address opens a new beat
		if (!i_cycle_begin_strobe_n || i_addr !== last_r) begin
			done_r = 1'b0;
			cnt = 0;
		end
		last_r = i_addr;
		if (!i_cs_n && !done_r && !i_mute) begin
			if (cnt >= i_wait) begin
				o_beat_acknowledge_n <= 1'b0;
				o_data <= {mb(i_addr), mb(i_addr + 28'h1), mb(i_addr + 28'h2),
					mb(i_addr + 28'h3)};
				done_r = 1'b1;
			end else begin
				cnt++;
			end
		end
	end
endmodule

//--- test_chip_select_burst_read_cycle.sv
// self-checking bench for the chip-select burst read sequencer
`timescale 1ns/10ps
`include "csb_defs.svh"
module test_chip_select_burst_read_cycle;
	logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, code = 1'b0, sup = 1'b0, burst = 1'b0;
	logic setup = 1'b0, hold = 1'b0, bmon = 1'b0, mute = 1'b0;
	logic [27:0] addr = 28'h0000000, addr_o;
	logic [1:0] kind = 2'h0, size = 2'h0, port = 2'h0, kcode, szc;
	// tight enough that a monitor which failed to restart per beat would trip in long bursts
	logic [7:0] limit = 8'h08;
	logic [3:0] waitc = 4'h0, wsn;
	logic ack_n, strobe_n, cls, rw, cs_n, busy, rdv, done, berr;
	logic [31:0] data, rdd;
	int err_total = 0;
	int num_checks = 0;
	logic [1:0] szt [7] = '{`CSB_OSZ_LONG, `CSB_OSZ_WORD, `CSB_OSZ_LONG, `CSB_OSZ_LINE,
		`CSB_OSZ_LINE, `CSB_OSZ_LONG, `CSB_OSZ_BYTE};
	logic [1:0] ptt [7] = '{`CSB_PORT_16, `CSB_PORT_8, `CSB_PORT_8, `CSB_PORT_16,
		`CSB_PORT_32, `CSB_PORT_32, `CSB_PORT_8};

	always #50 clk = ~clk;

	csb_read_seq dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_req_addr(addr),
		.i_req_kind(kind), .i_req_code(code), .i_req_super(sup), .i_req_size(size),
		.i_port_size(port), .i_burst_en(burst), .i_setup_delay_enable(setup),
		.i_addr_hold_en(hold), .i_bmon_en(bmon), .i_bmon_limit(limit),
		.i_beat_acknowledge_n(ack_n), .i_data(data), .o_addr(addr_o),
		.o_cycle_begin_strobe_n(strobe_n), .o_access_class_attr(cls),
		.o_access_kind_code(kcode), .o_operand_size_code(szc), .o_rw(rw),
		.o_write_strobe_n(wsn), .o_cs_n(cs_n), .o_busy(busy), .o_rd_data(rdd),
		.o_rd_valid(rdv), .o_done(done), .o_bus_error(berr));

	csb_mem_model mem_u (.i_sys_clk(clk), .i_addr(addr_o), .i_cs_n(cs_n),
		.i_cycle_begin_strobe_n(strobe_n), .i_mute(mute), .i_wait(waitc),
		.o_beat_acknowledge_n(ack_n), .o_data(data));

	// ****************************************
	// reference model and checking
	// ****************************************
	function automatic logic [31:0] word_at(input logic [27:0] a);
		return {a[7:0] ^ 8'h3c, 8'(a + 28'h1) ^ 8'h3c, 8'(a + 28'h2) ^ 8'h3c,
			8'(a + 28'h3) ^ 8'h3c};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic run_op(input logic [1:0] sz, input logic [1:0] pt, input logic bu);
		int nb, pw, beats, nstb, nack, nv, t, k;
		logic prev;
		logic [27:0] base;
		logic [31:0] w;
		logic [31:0] msk;
		logic [31:0] expq[$];
		nb = (sz == `CSB_OSZ_LINE) ? 16 : (sz == `CSB_OSZ_WORD) ? 2 : (sz == `CSB_OSZ_BYTE) ? 1 : 4;
		pw = (pt == `CSB_PORT_8) ? 1 : (pt == `CSB_PORT_16) ? 2 : 4;
		beats = nb / pw;
		base = 28'($urandom()) & 28'hffffff0;
		// short operands come back right-justified; first byte read ends highest
		msk = (nb < 4) ? ((32'h1 << (8 * nb)) - 32'h1) : 32'hffffffff;
		if (nb < 4) begin
			expq.push_back(word_at(base) >> (8 * (4 - nb)));
		end else begin
			for (k = 0; k < nb / 4; k++) begin
				expq.push_back(word_at(base + 28'(k * 4)));
			end
		end
		addr = base;
		size = sz;
		port = pt;
		burst = bu;
		{kind, code, sup, setup, hold, bmon} = 7'($urandom());
		waitc = 4'($urandom_range(0, 3));
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		nstb = 0;
		nack = 0;
		nv = 0;
		prev = 1'b0;
		for (t = 0; t < 300; t++) begin
			if (prev) begin
				chk("strobe c2", 1, strobe_n);
				chk("class c2", sup, cls);
			end
			prev = (strobe_n === 1'b0);
			if (prev) begin
				chk("class c1", code, cls);
				chk("busy", 1, busy);
				chk("start addr", base + 28'(nstb * pw), addr_o);
				chk("kind", kind, kcode);
				chk("size", (bu || beats == 1) ? sz : pt, szc);
				chk("rw", 1, rw);
				chk("write strobes", 4'hf, wsn);
				chk("cs c1", setup, cs_n);
				nstb++;
			end
			if (ack_n === 1'b0) begin
				chk("beat addr", base + 28'(nack * pw), addr_o);
				nack++;
			end
			if (rdv === 1'b1) begin
				w = (expq.size() > 0) ? expq.pop_front() : 32'hxxxxxxxx;
				chk("rd data", w, rdd & msk);
				nv++;
			end
			chk("no error", 0, berr);
			if (done === 1'b1) begin
				break;
			end
			@(negedge clk);
		end
		chk("done", 1, done);
		chk("strobes", (bu || beats == 1) ? 1 : beats, nstb);
		chk("beats", beats, nack);
		chk("valid words", (nb + 3) / 4, nv);
		@(negedge clk);
		chk("cs after done", 1, cs_n);
		for (t = 0; t < 5 && busy !== 1'b0; t++) begin
			@(negedge clk);
		end
		chk("idle", 0, busy);
	endtask

	task automatic run_timeout();
		int t;
		mute = 1'b1;
		bmon = 1'b1;
		limit = 8'h04;
		setup = 1'b0;
		hold = 1'b0;
		size = `CSB_OSZ_LONG;
		port = `CSB_PORT_16;
		burst = 1'b1;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		for (t = 0; t < 40 && berr !== 1'b1; t++) begin
			@(negedge clk);
		end
		chk("bus error", 1, berr);
		chk("no done", 0, done);
		@(negedge clk);
		chk("cs after error", 1, cs_n);
		mute = 1'b0;
		limit = 8'h08;
		for (t = 0; t < 5 && busy !== 1'b0; t++) begin
			@(negedge clk);
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(78935));
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 7; i++) begin
				run_op(szt[i], ptt[i], 1'b1);
				run_op(szt[i], ptt[i], 1'b0);
			end
		end
		run_timeout();
		// recovery after an abandoned burst
		run_op(`CSB_OSZ_LONG, `CSB_PORT_16, 1'b1);
		stop_test();
	end

	// the whole run needs several hundred cycles; this cuts a hang short
	initial begin
		#4000000;
		err_total++;
		stop_test();
	end
endmodule
